// file: hdl/timer_pkg.sv
package timer_pkg;

    // register map, byte-wide data
    localparam logic [7:0] OFF_PRESET_LOW  = 8'h0B;
    localparam logic [7:0] OFF_PRESET_HIGH = 8'h0C;
    localparam logic [7:0] OFF_EXTENSION   = 8'h0D;
    localparam logic [7:0] OFF_FLAGS       = 8'h0E;
    localparam logic [7:0] OFF_CONTROL     = 8'h0F;
    localparam logic [7:0] OFF_HOLD        = 8'h10;

    // extension_settings fields
    localparam int EXT_RUN_BIT    = 4;
    localparam int EXT_SEL_HI_BIT = 1;
    localparam int EXT_SEL_LO_BIT = 0;
    localparam logic [6:0] EXT_RESET  = 7'h00;

    // event_flags fields
    localparam int FLAG_EVENT_BIT = 4;

    // control_settings fields
    localparam int CTRL_ALERT_BIT = 4;
    localparam int CTRL_STOP_BIT  = 1;
    localparam logic [6:0] CTRL_WR_MASK = 7'h7A;
    localparam logic [6:0] CTRL_RESET   = 7'h00;

    // hold_settings fields
    localparam int HOLD_RESET_BIT = 0;

    // preset storage reset values and count compare constants
    localparam logic [7:0] PRESET_LOW_RESET  = 8'h00;
    localparam logic [3:0] PRESET_HIGH_RESET = 4'h0;
    localparam logic [11:0] COUNT_ONE        = 12'h001;
    localparam logic [11:0] COUNT_ZERO       = 12'h000;

    // time base dividers
    localparam int OSC_PER_FAST   = 8;
    localparam int FAST_PER_64HZ  = 64;
    localparam int FAST_PER_1HZ   = 4096;
    localparam int SEC_PER_MINUTE = 60;

    // auto release times
    localparam int CLK_PERIOD_NS       = 100;
    localparam int RELEASE_FAST_NS     = 122000;
    localparam int RELEASE_SLOW_NS     = 7813000;
    localparam int RELEASE_FAST_CYCLES = RELEASE_FAST_NS / CLK_PERIOD_NS;
    localparam int RELEASE_SLOW_CYCLES = RELEASE_SLOW_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SRC_4096HZ = 2'b00,
        SRC_64HZ   = 2'b01,
        SRC_1HZ    = 2'b10,
        SRC_MINUTE = 2'b11
    } src_sel_t;

endpackage

// file: hdl/edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      rise
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise = sync_r & ~last_r;
endmodule
`default_nettype wire

// file: hdl/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int RATIO = 2
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic tickIn,
    input  wire logic hold,
    output logic      tickOut
);
    localparam int W = (RATIO > 2) ? $clog2(RATIO) : 1;
    localparam logic [W-1:0] LAST = W'(RATIO - 1);

    logic [W-1:0] cnt_r;
    wire          wrap = tickIn & ~hold & (cnt_r == LAST);

    // hold freezes the phase instead of clearing it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r   <= '0;
            tickOut <= 1'b0;
        end else begin
            tickOut <= wrap;
            if (wrap) begin
                cnt_r <= '0;
            end else if (tickIn & ~hold) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/fixed_cycle_timer_interrupt.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_cycle_timer_interrupt #(
    parameter int RELEASE_SLOW = timer_pkg::RELEASE_SLOW_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       oscClk,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    output logic            irqOut,
    output logic            irqOe_b
);
    import timer_pkg::*;

    // register decode
    wire selLow   = (regAddr == OFF_PRESET_LOW);
    wire selHigh  = (regAddr == OFF_PRESET_HIGH);
    wire selExt   = (regAddr == OFF_EXTENSION);
    wire selFlags = (regAddr == OFF_FLAGS);
    wire selCtrl  = (regAddr == OFF_CONTROL);
    wire selHold  = (regAddr == OFF_HOLD);

    wire wrLow   = regWr & selLow;
    wire wrHigh  = regWr & selHigh;
    wire wrExt   = regWr & selExt;
    wire wrFlags = regWr & selFlags;
    wire wrCtrl  = regWr & selCtrl;
    wire wrHold  = regWr & selHold;

    // stored settings
    logic [7:0]  presetLow_r;
    logic [3:0]  presetHigh_r;
    logic [6:0]  extSettings_r;
    logic [6:0]  ctrlSettings_r;
    logic        countReset_r;
    logic        eventFlag_r;
    logic [11:0] count_r;
    logic        irqLow_r;
    logic [16:0] releaseCnt_r;
    logic [7:0]  regRdData_r;
    logic        irqOe_b_r;
    logic        irqOut_r;

    wire [11:0] preset      = {presetHigh_r, presetLow_r};
    wire        timerRun    = extSettings_r[EXT_RUN_BIT];
    wire        alertEnable = ctrlSettings_r[CTRL_ALERT_BIT];
    wire        stopBit     = ctrlSettings_r[CTRL_STOP_BIT];
    wire        srcSelHi    = extSettings_r[EXT_SEL_HI_BIT];
    wire        srcSelLo    = extSettings_r[EXT_SEL_LO_BIT];
    src_sel_t   srcSel;

    assign srcSel = src_sel_t'({srcSelHi, srcSelLo});

    // time base: oscillator edges feed a divider chain
    wire oscRise;
    wire tickFast;
    wire tick64;
    wire tickOneHz;
    wire tickSecond;
    wire tickMinute;
    wire chainHold = stopBit | countReset_r;

    edge_sync oscSync (
        .clk   (mclk),
        .rst_b (rst_b),
        .din   (oscClk),
        .rise  (oscRise)
    );

    tick_divider #(.RATIO(OSC_PER_FAST)) divFast (
        .clk     (mclk),
        .rst_b   (rst_b),
        .tickIn  (oscRise),
        .hold    (1'b0),
        .tickOut (tickFast)
    );

    tick_divider #(.RATIO(FAST_PER_64HZ)) div64 (
        .clk     (mclk),
        .rst_b   (rst_b),
        .tickIn  (tickFast),
        .hold    (chainHold),
        .tickOut (tick64)
    );

    // free-running 1 Hz, not tied to the clock chain
    tick_divider #(.RATIO(FAST_PER_1HZ)) divOneHz (
        .clk     (mclk),
        .rst_b   (rst_b),
        .tickIn  (tickFast),
        .hold    (1'b0),
        .tickOut (tickOneHz)
    );

    // timekeeping seconds and minute update, frozen by stop or reset
    tick_divider #(.RATIO(FAST_PER_1HZ)) divSecond (
        .clk     (mclk),
        .rst_b   (rst_b),
        .tickIn  (tickFast),
        .hold    (chainHold),
        .tickOut (tickSecond)
    );

    tick_divider #(.RATIO(SEC_PER_MINUTE)) divMinute (
        .clk     (mclk),
        .rst_b   (rst_b),
        .tickIn  (tickSecond),
        .hold    (chainHold),
        .tickOut (tickMinute)
    );

    // source clock selection
    wire srcIsFast = (srcSel == SRC_4096HZ);
    wire srcTick   = (srcSel == SRC_4096HZ) ? tickFast :
                     (srcSel == SRC_64HZ)   ? tick64 :
                     (srcSel == SRC_1HZ)    ? tickOneHz :
                                              tickMinute;
    // the 1 Hz divider never stops, so stop gates its ticks here instead
    wire srcGated  = ~srcIsFast & chainHold;

    // run bit edges and flag/alert clearing writes as seen on the register port
    wire runRise  = wrExt & regWrData[EXT_RUN_BIT] & ~timerRun;
    wire runFall  = wrExt & ~regWrData[EXT_RUN_BIT] & timerRun;
    wire flagClr  = wrFlags & ~regWrData[FLAG_EVENT_BIT] & eventFlag_r;
    wire alertClr = wrCtrl & ~regWrData[CTRL_ALERT_BIT] & alertEnable;

    // countdown
    wire countTick  = timerRun & srcTick & ~srcGated & ~runFall;
    wire countAtOne = (count_r == COUNT_ONE);
    wire countAtZero = (count_r == COUNT_ZERO);
    wire countStep  = countTick & ~countAtZero;
    // a tick that meets the start write is dropped so the fresh preset counts in full
    wire timerEvent = countTick & countAtOne & ~runRise;

    logic [11:0] count_nxt;
    always_comb begin
        count_nxt = count_r;
        if (runRise) begin
            count_nxt = preset;
        end else if (timerEvent) begin
            count_nxt = preset;
        end else if (countStep) begin
            count_nxt = count_r - 12'h001;
        end
        // a zero count never moves, so no event comes of it
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= COUNT_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end

    // event flag: a new event beats a clearing write in the same cycle
    wire eventFlag_nxt = timerEvent | (eventFlag_r & ~flagClr);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            eventFlag_r <= 1'b0;
        end else begin
            eventFlag_r <= eventFlag_nxt;
        end
    end

    // interrupt drive and auto release
    wire        irqSet      = timerEvent & alertEnable;
    wire        releaseDone = irqLow_r & (releaseCnt_r == 17'h0_0001);
    wire        irqDrop     = runFall | flagClr | alertClr | releaseDone;
    wire [16:0] releaseLoad = srcIsFast ? 17'(RELEASE_FAST_CYCLES) :
                                          17'(RELEASE_SLOW);

    logic irqLow_nxt;
    always_comb begin
        irqLow_nxt = irqLow_r;
        if (irqSet) begin
            irqLow_nxt = 1'b1;
        end else if (irqDrop) begin
            irqLow_nxt = 1'b0;
        end
    end

    wire         releaseRun = irqLow_r & (releaseCnt_r != 17'h0_0000);
    logic [16:0] releaseCnt_nxt;
    always_comb begin
        releaseCnt_nxt = releaseCnt_r;
        if (irqSet) begin
            releaseCnt_nxt = releaseLoad;
        end else if (releaseRun) begin
            releaseCnt_nxt = releaseCnt_r - 17'h0_0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irqLow_r <= 1'b0;
        end else begin
            irqLow_r <= irqLow_nxt;
        end
    end

    // counter only runs while the pin is held low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            releaseCnt_r <= 17'h0_0000;
        end else begin
            releaseCnt_r <= releaseCnt_nxt;
        end
    end

    // open drain pin: enable low means pulling the line low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irqOe_b_r <= 1'b1;
        end else begin
            irqOe_b_r <= ~irqLow_nxt;
        end
    end

    // the drive value never changes; only the enable moves the line
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irqOut_r <= 1'b0;
        end else begin
            irqOut_r <= 1'b0;
        end
    end

    // register writes
    wire [6:0] ctrl_nxt = (regWrData[6:0] & CTRL_WR_MASK) |
                          (ctrlSettings_r & ~CTRL_WR_MASK);

    // preset writes are taken even while running; the next event may be off
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            presetLow_r <= PRESET_LOW_RESET;
        end else if (wrLow) begin
            presetLow_r <= regWrData;
        end
    end

    // upper nibble only; bits 7 to 4 always read zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            presetHigh_r <= PRESET_HIGH_RESET;
        end else if (wrHigh) begin
            presetHigh_r <= regWrData[3:0];
        end
    end

    // test bit is never stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            extSettings_r <= EXT_RESET;
        end else if (wrExt) begin
            extSettings_r <= regWrData[6:0];
        end
    end

    // protected bits keep their value
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlSettings_r <= CTRL_RESET;
        end else if (wrCtrl) begin
            ctrlSettings_r <= ctrl_nxt;
        end
    end

    // counter reset holds the slow chain like stop does
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            countReset_r <= 1'b0;
        end else if (wrHold) begin
            countReset_r <= regWrData[HOLD_RESET_BIT];
        end
    end

    // read path: counter view depends on the run bit
    wire [11:0] countView = timerRun ? count_r : preset;

    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        if (selLow) begin
            rdMux = countView[7:0];
        end else if (selHigh) begin
            rdMux = {4'h0, countView[11:8]};
        end else if (selExt) begin
            rdMux = {1'b0, extSettings_r};
        end else if (selFlags) begin
            rdMux = 8'h00;
            rdMux[FLAG_EVENT_BIT] = eventFlag_r;
        end else if (selCtrl) begin
            rdMux = {1'b0, ctrlSettings_r};
        end else if (selHold) begin
            rdMux = 8'h00;
            rdMux[HOLD_RESET_BIT] = countReset_r;
        end
    end

    // data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_r <= 8'h00;
        end else begin
            regRdData_r <= regRd ? rdMux : 8'h00;
        end
    end

    assign regRdData = regRdData_r;
    assign irqOe_b   = irqOe_b_r;
    assign irqOut    = irqOut_r;

endmodule
`default_nettype wire

// file: dv/osc_source.sv
`timescale 1ns/1ps
`default_nettype none
module osc_source #(
    parameter int HALF_NS = 400
) (
    output logic oscClk
);
    // free running crystal, phase unrelated to mclk on purpose
    initial begin
        oscClk = 1'b0;
        #137;
        forever #(HALF_NS) oscClk = ~oscClk;
    end
endmodule
`default_nettype wire

// file: dv/timer_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timer_checker
    import timer_pkg::*;
#(
    parameter int RELEASE_SLOW = 50
) (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       oscClk,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic       irqOut,
    input wire logic       irqOe_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // consecutive low cycles on the pin; saturates so a stuck line keeps failing
    localparam int RELEASE_MAX = (RELEASE_FAST_CYCLES > RELEASE_SLOW) ? RELEASE_FAST_CYCLES : RELEASE_SLOW;
    logic [16:0] lowRun_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lowRun_r <= 17'h0_0000;
        end else if (irqOe_b) begin
            lowRun_r <= 17'h0_0000;
        end else if (lowRun_r != 17'h1_FFFF) begin
            lowRun_r <= lowRun_r + 17'h0_0001;
        end
    end

    a_drive_zero: assert property (irqOut == 1'b0)
        else $error("pin drive value not zero");
    a_read_idle: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data outside read cycle");
    a_high_nibble: assert property (regRd && regAddr == OFF_PRESET_HIGH |=> regRdData[7:4] == 4'h0)
        else $error("preset high upper bits not zero");
    a_stop_release: assert property (regWr && regAddr == OFF_EXTENSION && !regWrData[EXT_RUN_BIT] |=> irqOe_b)
        else $error("irq kept low after stop");
    a_flag_release: assert property (regWr && regAddr == OFF_FLAGS && !regWrData[FLAG_EVENT_BIT] |=> irqOe_b)
        else $error("irq kept low after flag clear");
    a_alert_release: assert property (regWr && regAddr == OFF_CONTROL && !regWrData[CTRL_ALERT_BIT] |=> irqOe_b)
        else $error("irq kept low after alert clear");
    a_auto_release: assert property (lowRun_r <= 17'(RELEASE_MAX))
        else $error("irq not released in time");
    a_low_flag_set: assert property (regRd && regAddr == OFF_FLAGS && !irqOe_b |=> regRdData[FLAG_EVENT_BIT])
        else $error("irq low without event flag");

    cover property ($fell(irqOe_b));
    cover property ($rose(irqOe_b));
    cover property (regRd && regAddr == OFF_FLAGS);
    cover property (lowRun_r == 17'(RELEASE_SLOW));
endmodule
bind fixed_cycle_timer_interrupt timer_checker #(.RELEASE_SLOW(RELEASE_SLOW)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .oscClk(oscClk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irqOut(irqOut), .irqOe_b(irqOe_b));
`default_nettype wire

// file: dv/fixed_cycle_timer_interrupt_test.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_cycle_timer_interrupt_test;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    logic       mclk, rst_b, oscClk, regWr, regRd, irqOut, irqOe_b, sawLow;
    logic [7:0] regAddr, regWrData, regRdData, d;
    int         err_total, total_checks, cyc, lowAt, t1;
    row_t       rows [9];

    fixed_cycle_timer_interrupt #(.RELEASE_SLOW(50)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .oscClk(oscClk), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irqOut(irqOut), .irqOe_b(irqOe_b));
    osc_source u_osc (.oscClk(oscClk));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (irqOe_b === 1'b0) sawLow <= 1'b1;
    end

    task chkByte(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task chkBit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge mclk);
        regWr <= 1'b1; regAddr <= a; regWrData <= w;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #10 d = regRdData;
    endtask
    // stop, clear, then load: the safe order for new settings
    task start(input logic [11:0] p, input logic [1:0] s, input logic [7:0] ctl);
        wr(8'h0D, 8'h00);
        wr(8'h0E, 8'h00);
        wr(8'h0B, p[7:0]);
        wr(8'h0C, {4'h0, p[11:8]});
        wr(8'h0F, ctl);
        wr(8'h0D, {6'h04, s});
        sawLow = 1'b0;
    endtask
    task waitLow(input int n);
        for (int i = 0; i < n && irqOe_b !== 1'b0; i++) @(posedge mclk);
        #1 lowAt = cyc;
        chkBit("irq low", 1'b0, irqOe_b);
    endtask
    task summarize;
        $display("mismatches %0d checks %0d", err_total, total_checks);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        // tests need about 25000 cycles; this allows twice that
        #5_000_000;
        err_total++;
        summarize();
    end

    initial begin
        rst_b = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWrData = 8'h00;
        cyc = 0; sawLow = 1'b0; err_total = 0; total_checks = 0;
        rows = '{'{8'h0B, 8'hA5, 8'hA5}, '{8'h0C, 8'hFF, 8'h0F}, '{8'h0D, 8'hAF, 8'h2F},
                 '{8'h0D, 8'h6E, 8'h6E}, '{8'h0D, 8'h01, 8'h01}, '{8'h0F, 8'hFF, 8'h7A},
                 '{8'h0E, 8'hFF, 8'h00}, '{8'h20, 8'h55, 8'h00}, '{8'h10, 8'h01, 8'h01}};
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chkByte("reg readback", rows[i].e, d);
        end
        // second reset in mid-run wipes every setting
        @(posedge mclk) rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        for (int a = 11; a < 16; a++) begin
            rd(a[7:0]);
            chkByte("reset value", 8'h00, d);
        end
        chkBit("irq released", 1'b1, irqOe_b);
        chkBit("irq drive value", 1'b0, irqOut);
        start(12'h002, 2'b00, 8'h10);
        waitLow(400);
        t1 = lowAt;
        wr(8'h0E, 8'h00);
        #10 chkBit("flag clear release", 1'b1, irqOe_b);
        waitLow(400);
        chkByte("event interval", 8'h80, 8'(lowAt - t1));
        rd(8'h0E);
        chkByte("event flag", 8'h10, d);
        wr(8'h0F, 8'h00);
        #10 chkBit("alert clear release", 1'b1, irqOe_b);
        wr(8'h0F, 8'h10);
        waitLow(400);
        wr(8'h0D, 8'h00);
        #10 chkBit("stop release", 1'b1, irqOe_b);
        start(12'h123, 2'b01, 8'h02);
        wr(8'h0B, 8'h55);
        rd(8'h0B);
        chkByte("live count low", 8'h23, d);
        rd(8'h0C);
        chkByte("live count high", 8'h01, d);
        wr(8'h0D, 8'h00);
        rd(8'h0B);
        chkByte("stopped preset view", 8'h55, d);
        start(12'h001, 2'b01, 8'h10);
        waitLow(5000);
        repeat (48) @(posedge mclk);
        #10 chkBit("irq held", 1'b0, irqOe_b);
        repeat (4) @(posedge mclk);
        #10 chkBit("auto release", 1'b1, irqOe_b);
        start(12'h001, 2'b10, 8'h10);
        repeat (4500) @(posedge mclk);
        chkBit("one hz source quiet", 1'b0, sawLow);
        start(12'h001, 2'b11, 8'h10);
        repeat (4500) @(posedge mclk);
        chkBit("minute source quiet", 1'b0, sawLow);
        start(12'h001, 2'b01, 8'h12);
        repeat (9000) @(posedge mclk);
        rd(8'h0E);
        chkByte("stopped slow source", 8'h00, d);
        start(12'h001, 2'b00, 8'h12);
        waitLow(400);
        start(12'h000, 2'b00, 8'h10);
        repeat (300) @(posedge mclk);
        chkBit("zero preset irq", 1'b0, sawLow);
        rd(8'h0E);
        chkByte("zero preset flag", 8'h00, d);
        start(12'h001, 2'b00, 8'h00);
        repeat (200) @(posedge mclk);
        chkBit("masked irq", 1'b0, sawLow);
        rd(8'h0E);
        chkByte("masked flag", 8'h10, d);
        summarize();
    end
endmodule
`default_nettype wire
